//--- bench/pit_apb_host.sv
// Purpose: processor-side APB master model driving the timer registers
// Assumes: one clock; the slave answers with pready when it is ready
// Notes:   address and data are inverted once released, so stale values never look valid
`timescale 1ns/100ps
module pit_apb_host
    import pit_pkg::*;
(
    // clock
    input  wire logic              clk,
    // apb request
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [31:0]            pwdata,
    // apb answer
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    // idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // -----------------------------------------------------------------
    // one whole transfer; the count is always read as one full word
    // -----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // request held until pready is sampled high; bounded so a hang ends
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        ok  = (pready === 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule // pit_apb_host

//--- bench/tb_periodic_interrupt_timer.sv
// Purpose: self-checking bench for the periodic interrupt timer
// Assumes: one 100 MHz clock, reset held four cycles
// Notes:   count samples are one clock old, so run checks use ranges
`timescale 1ns/100ps
module tb_periodic_interrupt_timer
    import pit_pkg::*;
;
    localparam logic [7:0] M_EN  = 8'(1 << BIT_EN);
    localparam logic [7:0] M_RLD = 8'(1 << BIT_RLD);
    localparam logic [7:0] M_FLG = 8'(1 << BIT_FLAG);
    localparam logic [7:0] M_IE  = 8'(1 << BIT_IE);
    localparam logic [7:0] M_OVW = 8'(1 << BIT_OVW);

    logic              clk;
    logic              rst_n;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              dozeMode;
    logic              debugMode;
    logic              irq;
    int                errCount;
    int                checked;

    // -----------------------------------------------------------------
    // design, host model and clock
    // -----------------------------------------------------------------
    pit_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dozeMode(dozeMode), .debugMode(debugMode), .irq(irq));
    pit_apb_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // -----------------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmpRange(input string name, input logic [15:0] lo, input logic [15:0] hi,
                            input logic [15:0] got);
        checked++;
        if ($isunknown(got) || !(got >= lo && got <= hi)) begin
            errCount++;
            $display("unexpected %s expected %h..%h seen %h", name, lo, hi, got);
        end
    endtask

    // a missing pready ends the run at once
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [15:0] v, output logic err);
        logic [31:0] rd;
        logic        ok;
        i_host.xfer(wr, a, d, rd, err, ok);
        v = rd[15:0];
        if (ok !== 1'b1) begin
            errCount++;
            $display("unexpected pready expected 1 seen timeout");
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] v;
        logic        e;
        bus(1'b1, a, {16'h0, d}, v, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        logic e;
        bus(1'b0, a, 32'h0, v, e);
    endtask

    function automatic logic [15:0] csr(input logic [3:0] pre, input logic [7:0] bits);
        return {4'h0, pre, bits};
    endfunction

    task automatic setMode(input int b, input logic v);
        @(posedge clk);
        if (b == BIT_DOZE) begin
            dozeMode <= v;
        end else begin
            debugMode <= v;
        end
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic tResetAccess();
        logic [15:0] v;
        logic        e;
        rd(OFS_CSR, v);
        cmp("control reset", 16'h0000, v);
        rd(OFS_MOD, v);
        cmp("modulus reset", 16'hffff, v);
        bus(1'b0, 8'h0c, 32'h0, v, e);
        cmp("unmapped error", 16'h0001, 16'(e));
        bus(1'b1, OFS_CNT, 32'h1234, v, e);
        cmp("count write error", 16'h0000, 16'(e));
        repeat (10) @(posedge clk);
        rd(OFS_CNT, v);
        cmp("count held", 16'hffff, v);
    endtask

    task automatic tLoad();
        logic [15:0] v;
        wr(OFS_CSR, csr(4'h0, M_OVW));
        wr(OFS_MOD, 16'h0001);
        rd(OFS_CNT, v);
        cmp("immediate load", 16'h0001, v);
        wr(OFS_CSR, 16'h0000);
        wr(OFS_MOD, 16'h0007);
        rd(OFS_CNT, v);
        cmp("deferred load", 16'h0001, v);
        rd(OFS_MOD, v);
        cmp("modulus readback", 16'h0007, v);
        wr(OFS_CSR, csr(4'h0, M_EN | M_RLD));
        repeat (12) @(posedge clk);
        rd(OFS_CNT, v);
        cmpRange("reloaded count", 16'h0000, 16'h0007, v);
        wr(OFS_CSR, csr(4'h0, M_OVW));
        wr(OFS_MOD, 16'h0002);
        wr(OFS_CSR, csr(4'h0, M_EN | M_OVW));
        repeat (8) @(posedge clk);
        rd(OFS_CNT, v);
        cmpRange("wrapped count", 16'hffe0, 16'hffff, v);
        wr(OFS_CSR, 16'h0000);
    endtask

    // a mid-run reset must drop a standing flag and restore the modulus
    task automatic tMidReset();
        logic [15:0] v;
        rd(OFS_CSR, v);
        cmp("flag before reset", 16'(M_FLG), v & 16'(M_FLG));
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CSR, v);
        cmp("control after reset", 16'h0000, v);
        rd(OFS_MOD, v);
        cmp("modulus after reset", 16'hffff, v);
    endtask

    task automatic tFlag();
        logic [15:0] v;
        logic        seen;
        int          n;
        wr(OFS_CSR, csr(4'h0, M_OVW | M_RLD));
        wr(OFS_MOD, 16'h0003);
        wr(OFS_CSR, csr(4'h0, M_EN | M_RLD | M_IE | M_OVW));
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        cmp("irq raised", 16'h0001, 16'(irq));
        if (irq !== 1'b1) begin
            summarize();
        end
        wr(OFS_CSR, csr(4'h0, M_RLD | M_IE));
        rd(OFS_CSR, v);
        cmp("flag after zero write", 16'(M_FLG), v & 16'(M_FLG));
        cmp("irq standing", 16'h0001, 16'(irq));
        wr(OFS_CSR, csr(4'h0, M_RLD | M_IE | M_FLG));
        rd(OFS_CSR, v);
        cmp("flag after one write", 16'h0000, v & 16'(M_FLG));
        cmp("irq dropped", 16'h0000, 16'(irq));
        wr(OFS_CSR, csr(4'h0, M_EN | M_RLD | M_OVW));
        seen = 1'b0;
        repeat (30) begin
            @(posedge clk);
            seen = seen | irq;
        end
        cmp("irq masked", 16'h0000, 16'(seen));
        wr(OFS_CSR, csr(4'h0, M_RLD));
        rd(OFS_CSR, v);
        cmp("flag while masked", 16'(M_FLG), v & 16'(M_FLG));
        wr(OFS_MOD, 16'h0005);
        rd(OFS_CSR, v);
        cmp("flag after modulus write", 16'h0000, v & 16'(M_FLG));
        wr(OFS_CSR, 16'h0000);
    endtask

    // counts over 256 cycles fall by 256 >> pre, give or take a phase step
    task automatic tPrescale(input logic [3:0] pre);
        logic [15:0] c1;
        logic [15:0] c2;
        logic [15:0] ex;
        ex = 16'd256 >> pre;
        wr(OFS_CSR, csr(4'h0, M_OVW));
        wr(OFS_MOD, 16'hffff);
        wr(OFS_CSR, csr(pre, M_EN | M_OVW));
        rd(OFS_CNT, c1);
        repeat (253) @(posedge clk);
        rd(OFS_CNT, c2);
        cmpRange("ticks per 256 clocks", ex - 16'd1, ex + 16'd1, c1 - c2);
        wr(OFS_CSR, csr(pre, M_OVW));
        rd(OFS_CNT, c1);
        repeat (20) @(posedge clk);
        rd(OFS_CNT, c2);
        cmp("count while disabled", c1, c2);
    endtask

    task automatic tFreeze(input int b);
        logic [15:0] c1;
        logic [15:0] c2;
        logic [7:0]  ctl;
        ctl = 8'(1 << b);
        setMode(b, 1'b1);
        wr(OFS_CSR, csr(4'h0, ctl | M_EN | M_OVW));
        wr(OFS_MOD, 16'h1234);
        repeat (20) @(posedge clk);
        rd(OFS_CNT, c1);
        cmp("update kept while frozen", 16'h1234, c1);
        wr(OFS_CSR, csr(4'h0, M_EN | M_OVW));
        repeat (20) @(posedge clk);
        rd(OFS_CNT, c1);
        cmpRange("run with control clear", 16'h1234 - 16'd40, 16'h1234 - 16'd10, c1);
        wr(OFS_CSR, csr(4'h0, ctl | M_EN | M_OVW));
        rd(OFS_CNT, c1);
        repeat (20) @(posedge clk);
        rd(OFS_CNT, c2);
        cmp("stopped by control set", c1, c2);
        setMode(b, 1'b0);
        repeat (20) @(posedge clk);
        rd(OFS_CNT, c2);
        cmpRange("resumed count", c1 - 16'd40, c1 - 16'd10, c2);
        wr(OFS_CSR, 16'h0000);
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        errCount  = 0;
        checked   = 0;
        rst_n     = 1'b0;
        dozeMode  = 1'b0;
        debugMode = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tResetAccess();
        tLoad();
        tMidReset();
        tFlag();
        tPrescale(4'h0);
        tPrescale(4'h2);
        tPrescale(4'h5);
        tFreeze(BIT_DOZE);
        tFreeze(BIT_DBG);
        summarize();
    end
endmodule // tb_periodic_interrupt_timer

//--- hdl/pit_counter.sv
// Purpose: 16-bit down counter with reload or wrap at zero
// Assumes: tick comes from the prescaler, one clk wide
// Notes:   an immediate load beats a tick in the same cycle
`timescale 1ns/100ps
module pit_counter
    import pit_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             tick,
    input  wire logic             ovwLoad,
    input  wire logic [CNT_W-1:0] ovwVal,
    input  wire logic             reloadSel,
    input  wire logic [CNT_W-1:0] modVal,
    // state out
    output logic [CNT_W-1:0]      count,
    output logic                  zeroHit,
    output logic                  loaded
);
    // a tick that finds zero is the timeout event
    assign zeroHit = tick && !ovwLoad && (count == ZERO_VAL);
    assign loaded  = ovwLoad || (zeroHit && reloadSel);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= RST_CNT;
        end else if (ovwLoad) begin
            count <= ovwVal;
        end else if (zeroHit) begin
            count <= reloadSel ? modVal : WRAP_VAL;
        end else if (tick) begin
            count <= count - 16'h0001;
        end
    end
endmodule // pit_counter

//--- hdl/pit_pkg.sv
// Purpose: constants shared by the periodic interrupt timer design
// Assumes: one 100 MHz clock, APB register access, 32-bit data
// Notes:   offsets are word aligned byte addresses

package pit_pkg;
    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam int          ADDR_W  = 8;
    localparam logic [7:0]  OFS_CSR = 8'h00;
    localparam logic [7:0]  OFS_MOD = 8'h04;
    localparam logic [7:0]  OFS_CNT = 8'h08;

    // -----------------------------------------------------------------
    // control and status field positions
    // -----------------------------------------------------------------
    localparam int BIT_EN   = 0;
    localparam int BIT_RLD  = 1;
    localparam int BIT_FLAG = 2;
    localparam int BIT_IE   = 3;
    localparam int BIT_OVW  = 4;
    localparam int BIT_DBG  = 5;
    localparam int BIT_DOZE = 6;
    localparam int PRE_LO   = 8;
    localparam int PRE_W    = 4;
    localparam int CNT_W    = 16;

    // -----------------------------------------------------------------
    // reset and special values
    // -----------------------------------------------------------------
    localparam logic [15:0] RST_MOD  = 16'hffff;
    localparam logic [15:0] RST_PSC  = 16'hffff;
    localparam logic [15:0] RST_CNT  = 16'hffff;
    localparam logic [15:0] WRAP_VAL = 16'hffff;
    localparam logic [15:0] ZERO_VAL = 16'h0000;
    localparam logic [3:0]  RST_PRE  = 4'h0;
    // cycles from setup edge to pready
    localparam int          ANS_CYC  = 1;
endpackage

//--- hdl/pit_prescaler.sv
// Purpose: power-of-two prescaler producing the counter tick
// Assumes: restart and run are synchronous to clk
// Notes:   tick is combinational, one clk wide
`timescale 1ns/100ps
module pit_prescaler
    import pit_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             run,
    input  wire logic             restart,
    input  wire logic [PRE_W-1:0] pre,
    // tick out
    output logic                  tick
);
    logic [15:0] pscCount;
    logic [15:0] mask;

    // low pre bits all zero marks the end of a 2**pre period
    assign mask = (16'h0001 << pre) - 16'h0001;
    assign tick = run && ((pscCount & mask) == 16'h0000);

    // down counter; a restart wins over counting
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pscCount <= RST_PSC;
        end else if (restart) begin
            pscCount <= RST_PSC;
        end else if (run) begin
            pscCount <= pscCount - 16'h0001;
        end
    end

    chk_psc_restart: assert property (
        @(posedge clk) disable iff (!rst_n)
        restart |=> pscCount == RST_PSC)
        else $error("prescaler not restarted");
endmodule // pit_prescaler

//--- hdl/pit_top.sv
// Purpose: periodic interrupt timer with APB register access
// Assumes: dozeMode and debugMode are synchronous levels from the chip
// Notes:   no wait state on any APB transfer; irq is registered
`timescale 1ns/100ps
module pit_top
    import pit_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // chip low-power and debug states
    input  wire logic              dozeMode,
    input  wire logic              debugMode,
    // interrupt request
    output logic                   irq
);
    // -----------------------------------------------------------------
    // control state
    // -----------------------------------------------------------------
    logic [PRE_W-1:0] preSel;
    logic             dozeCtl;
    logic             dbgCtl;
    logic             ovwSel;
    logic             irqEn;
    logic             flag;
    logic             reloadSel;
    logic             timerEn;
    logic [CNT_W-1:0] modLatch;
    logic             next_flag;

    // -----------------------------------------------------------------
    // bus decode
    // -----------------------------------------------------------------
    logic        setup;
    logic        access;
    logic        wrCsr;
    logic        wrMod;
    logic        wrCnt;
    logic        mapped;
    logic [31:0] readMux;

    // counter side
    logic             run;
    logic             tick;
    logic             ovwLoad;
    logic             preWrite;
    logic             zeroHit;
    logic             loaded;
    logic [CNT_W-1:0] count;
    logic             flagW1c;

    // setup is the first cycle of a transfer, access the completing edge
    assign setup  = psel && !penable;
    assign access = psel && penable && pready;
    assign wrCsr  = access && pwrite && (paddr == OFS_CSR);
    assign wrMod  = access && pwrite && (paddr == OFS_MOD);
    // count register accepts writes and drops them
    assign wrCnt  = access && pwrite && (paddr == OFS_CNT);
    assign mapped = (paddr == OFS_CSR) || (paddr == OFS_MOD) || (paddr == OFS_CNT);

    // -----------------------------------------------------------------
    // read data selection
    // -----------------------------------------------------------------
    // reserved bits read as zero
    always_comb begin
        readMux = 32'h0000_0000;
        case (paddr)
            OFS_CSR: begin
                readMux[PRE_LO +: PRE_W] = preSel;
                readMux[BIT_DOZE]        = dozeCtl;
                readMux[BIT_DBG]         = dbgCtl;
                readMux[BIT_OVW]         = ovwSel;
                readMux[BIT_IE]          = irqEn;
                readMux[BIT_FLAG]        = flag;
                readMux[BIT_RLD]         = reloadSel;
                readMux[BIT_EN]          = timerEn;
            end
            OFS_MOD: begin
                readMux[CNT_W-1:0] = modLatch;
            end
            OFS_CNT: begin
                readMux[CNT_W-1:0] = count;
            end
            default: begin
                readMux = 32'h0000_0000;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // apb answer
    // -----------------------------------------------------------------
    // data captured at setup so the outputs stay on flip-flops;
    // a read of the count is therefore one clock older than the end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : readMux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // -----------------------------------------------------------------
    // control and status register
    // -----------------------------------------------------------------
    // writes go through in any chip mode, so debug edits persist
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preSel    <= RST_PRE;
            dozeCtl   <= 1'b0;
            dbgCtl    <= 1'b0;
            ovwSel    <= 1'b0;
            irqEn     <= 1'b0;
            reloadSel <= 1'b0;
            timerEn   <= 1'b0;
        end else if (wrCsr) begin
            preSel    <= pwdata[PRE_LO +: PRE_W];
            dozeCtl   <= pwdata[BIT_DOZE];
            dbgCtl    <= pwdata[BIT_DBG];
            ovwSel    <= pwdata[BIT_OVW];
            irqEn     <= pwdata[BIT_IE];
            reloadSel <= pwdata[BIT_RLD];
            timerEn   <= pwdata[BIT_EN];
        end
    end

    // -----------------------------------------------------------------
    // modulus latch
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modLatch <= RST_MOD;
        end else if (wrMod) begin
            modLatch <= pwdata[CNT_W-1:0];
        end
    end

    // -----------------------------------------------------------------
    // timeout flag
    // -----------------------------------------------------------------
    // a zero hit in the clearing cycle wins so no timeout is lost
    assign flagW1c = wrCsr && pwdata[BIT_FLAG];
    always_comb begin
        next_flag = flag;
        if (zeroHit) begin
            next_flag = 1'b1;
        end else if (flagW1c || wrMod) begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    // request follows flag and enable with one clock of delay
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= flag && irqEn;
        end
    end

    // -----------------------------------------------------------------
    // run control and counting datapath
    // -----------------------------------------------------------------
    // freezing just withholds run, so all state resumes untouched
    assign run = timerEn
               && !(dozeCtl && dozeMode)
               && !(dbgCtl && debugMode);
    assign ovwLoad  = wrMod && ovwSel;
    assign preWrite = wrCsr && (pwdata[PRE_LO +: PRE_W] != preSel);

    pit_prescaler u_psc (
        .clk     (clk),
        .rst_n   (rst_n),
        .run     (run),
        .restart (preWrite || loaded),
        .pre     (preSel),
        .tick    (tick)
    );

    pit_counter u_cnt (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (tick),
        .ovwLoad   (ovwLoad),
        .ovwVal    (pwdata[CNT_W-1:0]),
        .reloadSel (reloadSel),
        .modVal    (modLatch),
        .count     (count),
        .zeroHit   (zeroHit),
        .loaded    (loaded)
    );

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    chk_doze_freeze: assert property (
        @(posedge clk) disable iff (!rst_n)
        (dozeCtl && dozeMode && !ovwLoad) |=> $stable(count))
        else $error("count moved in doze freeze");

    chk_debug_freeze: assert property (
        @(posedge clk) disable iff (!rst_n)
        (dbgCtl && debugMode && !ovwLoad) |=> $stable(count))
        else $error("count moved in debug freeze");

    chk_debug_restart: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wrCsr && pwdata[BIT_EN] && !pwdata[BIT_DBG])
        |=> (run || (dozeCtl && dozeMode)))
        else $error("clearing debug bit did not start");

    chk_latched_mod: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wrMod && !ovwSel && !tick) |=> $stable(count))
        else $error("modulus reached counter early");

    chk_ovw_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        ovwLoad |=> count == $past(pwdata[CNT_W-1:0]))
        else $error("immediate load missed");

    chk_irq_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        !irqEn |=> !irq)
        else $error("irq raised while disabled");

    chk_flag_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        zeroHit |=> flag)
        else $error("flag not set at zero");

    chk_flag_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((flagW1c || wrMod) && !zeroHit) |=> !flag)
        else $error("flag not cleared");

    chk_flag_keep: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wrCsr && !pwdata[BIT_FLAG] && !wrMod && flag) |=> flag)
        else $error("writing zero cleared flag");

    chk_wrap: assert property (
        @(posedge clk) disable iff (!rst_n)
        (zeroHit && !reloadSel) |=> count == WRAP_VAL)
        else $error("no wrap to all ones");

    chk_reload: assert property (
        @(posedge clk) disable iff (!rst_n)
        (zeroHit && reloadSel) |=> count == $past(modLatch))
        else $error("no reload from modulus");

    chk_enable_stop: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!timerEn && !ovwLoad) |=> $stable(count))
        else $error("count moved while disabled");

    chk_mod_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (setup && !pwrite && paddr == OFS_MOD)
        |=> prdata[CNT_W-1:0] == $past(modLatch))
        else $error("modulus read wrong");

    chk_mod_reset: assert property (
        @(posedge clk)
        !rst_n |=> modLatch == RST_MOD)
        else $error("modulus reset value wrong");

    chk_cnt_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (setup && pwrite && paddr == OFS_CNT) |=> (pready && !pslverr))
        else $error("count write not terminated");

    chk_div_one: assert property (
        @(posedge clk) disable iff (!rst_n)
        (run && preSel == 4'h0) |-> tick)
        else $error("divide by one lost a tick");

    chk_decrement: assert property (
        @(posedge clk) disable iff (!rst_n)
        (tick && !ovwLoad && count != ZERO_VAL)
        |=> count == $past(count) - 16'h0001)
        else $error("tick did not decrement");

    chk_irq_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flag && irqEn) [*2] |-> irq)
        else $error("irq dropped while flag set");

    cov_reload: cover property (
        @(posedge clk) disable iff (!rst_n)
        zeroHit && reloadSel);

    cov_wrap: cover property (
        @(posedge clk) disable iff (!rst_n)
        zeroHit && !reloadSel);

    cov_cnt_write: cover property (
        @(posedge clk) disable iff (!rst_n)
        wrCnt);

    cov_irq: cover property (
        @(posedge clk) disable iff (!rst_n)
        $rose(irq));

    cov_debug_freeze: cover property (
        @(posedge clk) disable iff (!rst_n)
        timerEn && dbgCtl && debugMode ##1 run);
endmodule // pit_top
